//--- rtl/eth_ring_pkg.sv
// Purpose: Constants and types for the transmit control and receive ring block
// Assumes: Byte-wide host register port, one 125 MHz clock
// Notes: Register address, bit position and reset value list below
package eth_ring_pkg;
	localparam logic [7:0] ADDR_CTRL_LO = 8'h00;
	localparam logic [7:0] ADDR_CTRL_HI = 8'h01;
	localparam logic [7:0] ADDR_CONFIG = 8'h02;
	localparam logic [7:0] ADDR_PENDING = 8'h03;
	localparam logic [7:0] ADDR_START_LO = 8'h04;
	localparam logic [7:0] ADDR_START_HI = 8'h05;
	localparam logic [7:0] ADDR_LEN_LO = 8'h06;
	localparam logic [7:0] ADDR_LEN_HI = 8'h07;
	localparam logic [7:0] ADDR_MAXLEN_LO = 8'h08;
	localparam logic [7:0] ADDR_MAXLEN_HI = 8'h09;
	localparam logic [7:0] ADDR_RING_LO = 8'h0a;
	localparam logic [7:0] ADDR_RING_HI = 8'h0b;
	localparam logic [7:0] ADDR_TAIL_LO = 8'h0c;
	localparam logic [7:0] ADDR_TAIL_HI = 8'h0d;
	localparam logic [7:0] ADDR_HEAD_LO = 8'h0e;
	localparam logic [7:0] ADDR_HEAD_HI = 8'h0f;
	localparam logic [7:0] ADDR_FLAGS_LO = 8'h10;
	localparam logic [7:0] ADDR_FLAGS_HI = 8'h11;
	localparam logic [7:0] ADDR_WIRE_LO = 8'h12;
	localparam logic [7:0] ADDR_WIRE_HI = 8'h13;
	localparam int CTRL_RECV_ENABLE = 0;
	localparam int CTRL_SEND_REQUEST = 1;
	localparam int CTRL_DECREMENT = 0;
	localparam int CFG_FULL_DUPLEX = 0;
	localparam int CFG_AUTO_CHECKSUM = 1;
	localparam int CFG_HUGE_FRAMES = 2;
	localparam int CFG_FLOW_CONTROL = 3;
	localparam int FLAG_LATE = 10;
	localparam int FLAG_RETRY = 9;
	localparam int FLAG_EXCESS = 8;
	localparam int FLAG_WAITED = 7;
	localparam int FLAG_CHECKSUM = 4;
	localparam logic [15:0] MEM_FIRST = 16'h0000;
	localparam logic [15:0] MEM_LAST = 16'h5fff;
	localparam logic [15:0] SEND_LEN_LOCKOUT = 16'h0007;
	localparam logic [7:0] CONFIG_RESET = 8'h02;
	localparam logic [15:0] MAXLEN_RESET = 16'h05ee;
	localparam logic [15:0] RING_RESET = 16'h3000;
	localparam logic [15:0] TAIL_RESET = 16'h5ffe;
	localparam logic [3:0] RETRY_LIMIT_RESET = 4'hf;
	localparam logic [7:0] PENDING_MAX = 8'hff;
	typedef enum {TX_IDLE, TX_RUN, TX_WAIT} tx_state_t;
endpackage

//--- rtl/eth_tx_control_rx_ring.sv
// Purpose: Transmit control, transmit byte FIFO and receive ring pointer logic
// Assumes: Memory read data is valid in the same cycle as the read strobe
// Notes: MAC serialiser events arrive as one-cycle pulses on the same clock
`timescale 1ns/1ns
`default_nettype none
module send_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic clear_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH];
	logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic push, pop;
	assign in_ready_o = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
	assign out_valid_o = wr_ptr != rd_ptr;
	assign out_data_o = store[rd_ptr[AW-1:0]];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	always_comb begin
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		if (clear_i) begin
			next_wr_ptr = '0;
			next_rd_ptr = '0;
		end
	end
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			store[wr_ptr[AW-1:0]] <= in_data_i;
		end
	end
endmodule

module eth_tx_control_rx_ring import eth_ring_pkg::*; #(
	parameter int FIFO_DEPTH = 16,
	parameter logic [3:0] RETRY_LIMIT = RETRY_LIMIT_RESET,
	parameter logic [15:0] RING_START_DEFAULT = RING_RESET
) (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic mem_rd_en_o,
	output logic [15:0] mem_rd_addr_o,
	input wire logic [7:0] mem_rd_data_i,
	output logic mem_wr_en_o,
	output logic [15:0] mem_wr_addr_o,
	output logic [7:0] mem_wr_data_o,
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	output logic [7:0] tx_data_o,
	output logic tx_last_o,
	output logic tx_crc_append_o,
	output logic jam_o,
	output logic send_done_o,
	output logic send_abort_o,
	input wire logic link_up_i,
	input wire logic pause_hold_i,
	input wire logic wire_byte_i,
	input wire logic mac_done_i,
	input wire logic collision_i,
	input wire logic late_collision_i,
	input wire logic excess_wait_i,
	input wire logic waited_i,
	input wire logic checksum_mismatch_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_last_i,
	input wire logic rx_reject_i
);
	tx_state_t tx_state, next_tx_state;
	logic send_request, next_send_request, recv_enable, next_recv_enable;
	logic [7:0] config_bits, next_config_bits, pending_frame_count, next_pending_frame_count;
	logic [15:0] send_start_address, next_send_start_address, send_length, next_send_length;
	logic [15:0] max_frame_length, next_max_frame_length, recv_ring_start, next_recv_ring_start;
	logic [15:0] recv_protect_pointer, next_recv_protect_pointer;
	logic [15:0] recv_write_pointer, next_recv_write_pointer, frame_base, next_frame_base;
	logic [7:0] head_shadow, next_head_shadow, next_reg_rdata;
	logic rx_dropping, next_rx_dropping;
	logic next_mem_wr_en;
	logic [15:0] next_mem_wr_addr;
	logic [7:0] next_mem_wr_data;
	logic [15:0] fetch_addr, next_fetch_addr, fetch_left, next_fetch_left;
	logic [15:0] out_count, next_out_count, work_flags, next_work_flags;
	logic [15:0] wire_work, next_wire_work, send_result_flags, next_send_result_flags;
	logic [15:0] send_wire_count, next_send_wire_count;
	logic [3:0] collision_tally, next_collision_tally;
	logic out_valid, next_out_valid, link_ok, next_link_ok, next_mem_rd_en;
	logic [15:0] next_mem_rd_addr;
	logic [7:0] next_tx_data;
	logic next_tx_last, next_tx_crc, next_tx_valid, next_jam, next_done, next_abort;
	logic fifo_clear, fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [7:0] fifo_out_data;
	logic wr_ctrl_lo, out_ready, half_duplex, pass_last, trunc_hit;
	logic [15:0] head_step, head_align;

	assign wr_ctrl_lo = reg_wr_i && reg_addr_i == ADDR_CTRL_LO;
	assign half_duplex = !config_bits[CFG_FULL_DUPLEX];
	assign out_ready = !out_valid || !link_ok || tx_ready_i;
	assign fifo_out_ready = tx_state == TX_RUN && out_ready;
	assign fifo_in_valid = mem_rd_en_o && tx_state == TX_RUN && !fifo_clear;
	assign pass_last = out_count + 16'h0001 == send_length;
	assign trunc_hit = !config_bits[CFG_HUGE_FRAMES] && out_count + 16'h0001 == max_frame_length;

	function automatic logic [15:0] fetch_step(input logic [15:0] a, input logic [15:0] ring);
		if (a >= ring) begin
			fetch_step = (a == MEM_LAST) ? ring : a + 16'h0001;
		end else begin
			fetch_step = (a == ring - 16'h0001) ? MEM_FIRST : a + 16'h0001;
		end
	endfunction

	function automatic logic [15:0] ring_step(input logic [15:0] a, input logic [15:0] ring);
		ring_step = (a == MEM_LAST) ? ring : a + 16'h0001;
	endfunction

	send_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.clear_i(fifo_clear),
		.in_valid_i(fifo_in_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i(mem_rd_data_i),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_out_data)
	);

	// Transmit control
	always_comb begin
		next_tx_state = tx_state;
		next_send_request = send_request;
		next_fetch_addr = fetch_addr;
		next_fetch_left = fetch_left;
		next_out_count = out_count;
		next_work_flags = work_flags;
		next_wire_work = wire_work;
		next_send_result_flags = send_result_flags;
		next_send_wire_count = send_wire_count;
		next_collision_tally = collision_tally;
		next_out_valid = out_valid;
		next_link_ok = link_ok;
		next_mem_rd_en = 1'b0;
		next_mem_rd_addr = mem_rd_addr_o;
		next_tx_data = tx_data_o;
		next_tx_last = tx_last_o;
		next_tx_crc = tx_crc_append_o;
		next_jam = 1'b0;
		next_done = 1'b0;
		next_abort = 1'b0;
		fifo_clear = 1'b0;
		if (wr_ctrl_lo && reg_wdata_i[CTRL_SEND_REQUEST] && send_length > SEND_LEN_LOCKOUT) begin
			next_send_request = 1'b1;
		end
		case (tx_state)
			TX_IDLE: begin
				if (wr_ctrl_lo && !reg_wdata_i[CTRL_SEND_REQUEST]) begin
					next_send_request = 1'b0;
				end
				if (send_request && !(pause_hold_i && config_bits[CFG_FLOW_CONTROL]
						&& config_bits[CFG_FULL_DUPLEX])) begin
					next_tx_state = TX_RUN;
					next_fetch_addr = send_start_address;
					next_fetch_left = send_length;
					next_out_count = '0;
					next_work_flags = '0;
					next_wire_work = '0;
					next_collision_tally = '0;
					next_link_ok = link_up_i;
					fifo_clear = 1'b1;
				end
			end
			default: begin
				if (link_ok && wire_byte_i) begin
					next_wire_work = wire_work + 16'h0001;
				end
				if (waited_i) begin
					next_work_flags[FLAG_WAITED] = 1'b1;
				end
				if (checksum_mismatch_i && !config_bits[CFG_AUTO_CHECKSUM]) begin
					next_work_flags[FLAG_CHECKSUM] = 1'b1;
				end
				if (tx_state == TX_RUN) begin
					if (fetch_left != '0 && !mem_rd_en_o && fifo_in_ready) begin
						next_mem_rd_en = 1'b1;
						next_mem_rd_addr = fetch_addr;
						next_fetch_addr = fetch_step(fetch_addr, recv_ring_start);
						next_fetch_left = fetch_left - 16'h0001;
					end
					if (out_valid && out_ready && tx_last_o) begin
						next_out_valid = 1'b0;
						next_tx_state = TX_WAIT;
					end else if (fifo_out_valid && out_ready) begin
						next_out_valid = 1'b1;
						next_tx_data = fifo_out_data;
						next_out_count = out_count + 16'h0001;
						next_tx_last = pass_last || trunc_hit;
						next_tx_crc = pass_last || !trunc_hit;
						if (trunc_hit && !pass_last) begin
							next_fetch_left = '0;
							next_mem_rd_en = 1'b0;
							fifo_clear = 1'b1;
						end
					end else if (out_valid && out_ready) begin
						next_out_valid = 1'b0;
					end
				end
				if (tx_state == TX_WAIT && (mac_done_i || !link_ok)) begin
					next_tx_state = TX_IDLE;
					next_send_request = 1'b0;
					next_done = 1'b1;
					next_send_result_flags = {work_flags[15:4], collision_tally};
					next_send_wire_count = next_wire_work;
				end
				if (link_ok && half_duplex && (late_collision_i || excess_wait_i
						|| (collision_i && collision_tally == RETRY_LIMIT))) begin
					next_tx_state = TX_IDLE;
					next_send_request = 1'b0;
					next_done = 1'b0;
					next_abort = 1'b1;
					next_out_valid = 1'b0;
					next_mem_rd_en = 1'b0;
					fifo_clear = 1'b1;
					next_send_result_flags = {work_flags[15:11], late_collision_i,
						collision_i && !late_collision_i && !excess_wait_i, excess_wait_i,
						work_flags[7:4], collision_tally};
					next_send_wire_count = next_wire_work;
				end else if (link_ok && half_duplex && collision_i) begin
					next_tx_state = TX_RUN;
					next_collision_tally = collision_tally + 4'h1;
					next_fetch_addr = send_start_address;
					next_fetch_left = send_length;
					next_out_count = '0;
					next_out_valid = 1'b0;
					next_mem_rd_en = 1'b0;
					fifo_clear = 1'b1;
				end
				if (wr_ctrl_lo && !reg_wdata_i[CTRL_SEND_REQUEST]) begin
					next_tx_state = TX_IDLE;
					next_send_request = 1'b0;
					next_jam = link_ok;
					next_done = 1'b0;
					next_abort = 1'b1;
					next_out_valid = 1'b0;
					next_mem_rd_en = 1'b0;
					fifo_clear = 1'b1;
					next_send_result_flags = {work_flags[15:4], collision_tally};
					next_send_wire_count = next_wire_work;
				end
			end
		endcase
		next_tx_valid = next_out_valid && next_link_ok;
	end

	// Host registers and receive ring
	always_comb begin
		next_recv_enable = recv_enable;
		next_config_bits = config_bits;
		next_send_start_address = send_start_address;
		next_send_length = send_length;
		next_max_frame_length = max_frame_length;
		next_recv_ring_start = recv_ring_start;
		next_recv_protect_pointer = recv_protect_pointer;
		next_recv_write_pointer = recv_write_pointer;
		next_frame_base = frame_base;
		next_pending_frame_count = pending_frame_count;
		next_head_shadow = head_shadow;
		next_rx_dropping = rx_dropping;
		next_mem_wr_en = 1'b0;
		next_mem_wr_addr = mem_wr_addr_o;
		next_mem_wr_data = mem_wr_data_o;
		next_reg_rdata = reg_rdata_o;
		head_step = recv_write_pointer;
		head_align = recv_write_pointer;
		if (reg_wr_i) begin
			if (reg_addr_i == ADDR_CTRL_LO) begin
				next_recv_enable = reg_wdata_i[CTRL_RECV_ENABLE];
			end else if (reg_addr_i == ADDR_CONFIG) begin
				next_config_bits = reg_wdata_i;
			end else if (reg_addr_i == ADDR_START_LO) begin
				next_send_start_address[7:0] = reg_wdata_i;
			end else if (reg_addr_i == ADDR_START_HI) begin
				next_send_start_address[15:8] = reg_wdata_i;
			end else if (reg_addr_i == ADDR_LEN_LO) begin
				next_send_length[7:0] = reg_wdata_i;
			end else if (reg_addr_i == ADDR_LEN_HI) begin
				next_send_length[15:8] = reg_wdata_i;
			end else if (reg_addr_i == ADDR_MAXLEN_LO) begin
				next_max_frame_length[7:0] = reg_wdata_i;
			end else if (reg_addr_i == ADDR_MAXLEN_HI) begin
				next_max_frame_length[15:8] = reg_wdata_i;
			end else if (reg_addr_i == ADDR_RING_LO) begin
				next_recv_ring_start[7:0] = {reg_wdata_i[7:1], 1'b0};
			end else if (reg_addr_i == ADDR_RING_HI) begin
				next_recv_ring_start[15:8] = reg_wdata_i;
			end else if (reg_addr_i == ADDR_TAIL_LO) begin
				next_recv_protect_pointer[7:0] = reg_wdata_i;
			end else if (reg_addr_i == ADDR_TAIL_HI) begin
				next_recv_protect_pointer[15:8] = reg_wdata_i;
			end
		end
		if (recv_enable && rx_valid_i) begin
			if (recv_write_pointer == recv_protect_pointer || rx_dropping) begin
				next_rx_dropping = 1'b1;
			end else begin
				next_mem_wr_en = 1'b1;
				next_mem_wr_addr = recv_write_pointer;
				next_mem_wr_data = rx_data_i;
				head_step = ring_step(recv_write_pointer, recv_ring_start);
			end
			head_align = head_step[0] ? ring_step(head_step, recv_ring_start) : head_step;
			next_recv_write_pointer = head_step;
			if (rx_last_i) begin
				if (next_rx_dropping || rx_reject_i || pending_frame_count == PENDING_MAX) begin
					next_recv_write_pointer = frame_base;
				end else begin
					next_recv_write_pointer = head_align;
					next_frame_base = head_align;
					next_pending_frame_count = pending_frame_count + 8'h01;
				end
				next_rx_dropping = 1'b0;
			end
		end
		if (reg_wr_i && reg_addr_i == ADDR_CTRL_HI && reg_wdata_i[CTRL_DECREMENT]
				&& pending_frame_count != '0) begin
			next_pending_frame_count = next_pending_frame_count - 8'h01;
		end
		if (reg_wr_i && (reg_addr_i == ADDR_RING_LO || reg_addr_i == ADDR_RING_HI)) begin
			next_recv_write_pointer = next_recv_ring_start;
			next_frame_base = next_recv_ring_start;
		end
		if (reg_rd_i) begin
			if (reg_addr_i == ADDR_CTRL_LO) begin
				next_reg_rdata = {6'h00, send_request, recv_enable};
			end else if (reg_addr_i == ADDR_CONFIG) begin
				next_reg_rdata = config_bits;
			end else if (reg_addr_i == ADDR_PENDING) begin
				next_reg_rdata = pending_frame_count;
			end else if (reg_addr_i == ADDR_START_LO) begin
				next_reg_rdata = send_start_address[7:0];
			end else if (reg_addr_i == ADDR_START_HI) begin
				next_reg_rdata = send_start_address[15:8];
			end else if (reg_addr_i == ADDR_LEN_LO) begin
				next_reg_rdata = send_length[7:0];
			end else if (reg_addr_i == ADDR_LEN_HI) begin
				next_reg_rdata = send_length[15:8];
			end else if (reg_addr_i == ADDR_MAXLEN_LO) begin
				next_reg_rdata = max_frame_length[7:0];
			end else if (reg_addr_i == ADDR_MAXLEN_HI) begin
				next_reg_rdata = max_frame_length[15:8];
			end else if (reg_addr_i == ADDR_RING_LO) begin
				next_reg_rdata = recv_ring_start[7:0];
			end else if (reg_addr_i == ADDR_RING_HI) begin
				next_reg_rdata = recv_ring_start[15:8];
			end else if (reg_addr_i == ADDR_TAIL_LO) begin
				next_reg_rdata = recv_protect_pointer[7:0];
			end else if (reg_addr_i == ADDR_TAIL_HI) begin
				next_reg_rdata = recv_protect_pointer[15:8];
			end else if (reg_addr_i == ADDR_HEAD_LO) begin
				next_reg_rdata = recv_write_pointer[7:0];
				next_head_shadow = recv_write_pointer[15:8];
			end else if (reg_addr_i == ADDR_HEAD_HI) begin
				next_reg_rdata = head_shadow;
			end else if (reg_addr_i == ADDR_FLAGS_LO) begin
				next_reg_rdata = send_result_flags[7:0];
			end else if (reg_addr_i == ADDR_FLAGS_HI) begin
				next_reg_rdata = send_result_flags[15:8];
			end else if (reg_addr_i == ADDR_WIRE_LO) begin
				next_reg_rdata = send_wire_count[7:0];
			end else if (reg_addr_i == ADDR_WIRE_HI) begin
				next_reg_rdata = send_wire_count[15:8];
			end else begin
				next_reg_rdata = '0;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tx_state <= TX_IDLE;
			send_request <= 1'b0;
			fetch_addr <= '0;
			fetch_left <= '0;
			out_count <= '0;
			work_flags <= '0;
			wire_work <= '0;
			send_result_flags <= '0;
			send_wire_count <= '0;
			collision_tally <= '0;
			out_valid <= 1'b0;
			link_ok <= 1'b0;
			mem_rd_en_o <= 1'b0;
			mem_rd_addr_o <= '0;
			tx_valid_o <= 1'b0;
			tx_data_o <= '0;
			tx_last_o <= 1'b0;
			tx_crc_append_o <= 1'b0;
			jam_o <= 1'b0;
			send_done_o <= 1'b0;
			send_abort_o <= 1'b0;
			recv_enable <= 1'b0;
			config_bits <= CONFIG_RESET;
			send_start_address <= '0;
			send_length <= '0;
			max_frame_length <= MAXLEN_RESET;
			recv_ring_start <= RING_START_DEFAULT;
			recv_protect_pointer <= TAIL_RESET;
			recv_write_pointer <= RING_START_DEFAULT;
			frame_base <= RING_START_DEFAULT;
			pending_frame_count <= '0;
			head_shadow <= '0;
			rx_dropping <= 1'b0;
			mem_wr_en_o <= 1'b0;
			mem_wr_addr_o <= '0;
			mem_wr_data_o <= '0;
			reg_rdata_o <= '0;
		end else begin
			tx_state <= next_tx_state;
			send_request <= next_send_request;
			fetch_addr <= next_fetch_addr;
			fetch_left <= next_fetch_left;
			out_count <= next_out_count;
			work_flags <= next_work_flags;
			wire_work <= next_wire_work;
			send_result_flags <= next_send_result_flags;
			send_wire_count <= next_send_wire_count;
			collision_tally <= next_collision_tally;
			out_valid <= next_out_valid;
			link_ok <= next_link_ok;
			mem_rd_en_o <= next_mem_rd_en;
			mem_rd_addr_o <= next_mem_rd_addr;
			tx_valid_o <= next_tx_valid;
			tx_data_o <= next_tx_data;
			tx_last_o <= next_tx_last;
			tx_crc_append_o <= next_tx_crc;
			jam_o <= next_jam;
			send_done_o <= next_done;
			send_abort_o <= next_abort;
			recv_enable <= next_recv_enable;
			config_bits <= next_config_bits;
			send_start_address <= next_send_start_address;
			send_length <= next_send_length;
			max_frame_length <= next_max_frame_length;
			recv_ring_start <= next_recv_ring_start;
			recv_protect_pointer <= next_recv_protect_pointer;
			recv_write_pointer <= next_recv_write_pointer;
			frame_base <= next_frame_base;
			pending_frame_count <= next_pending_frame_count;
			head_shadow <= next_head_shadow;
			rx_dropping <= next_rx_dropping;
			mem_wr_en_o <= next_mem_wr_en;
			mem_wr_addr_o <= next_mem_wr_addr;
			mem_wr_data_o <= next_mem_wr_data;
			reg_rdata_o <= next_reg_rdata;
		end
	end
endmodule
`default_nettype wire

//--- dv/eth_mac_model.sv
// Purpose: MAC side model taking bytes and reporting wire events
// Assumes: Same clock as the block
// Notes: slow_i accepts one byte in four
`timescale 1ns/1ns
`default_nettype none
module eth_mac_model (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic tx_valid_i,
	input wire logic tx_last_i,
	input wire logic slow_i,
	output logic tx_ready_o,
	output logic wire_byte_o,
	output logic mac_done_o
);
	logic [1:0] cnt;
	logic fin;
	assign tx_ready_o = !slow_i || cnt == 2'h3;
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			{cnt, fin, wire_byte_o, mac_done_o} <= '0;
		end else begin
			cnt <= cnt + 2'h1;
			wire_byte_o <= tx_valid_i && tx_ready_o;
			fin <= tx_valid_i && tx_ready_o && tx_last_i;
			mac_done_o <= fin;
		end
	end
endmodule
`default_nettype wire

//--- dv/eth_ring_chk.sv
// Purpose: Port assertions for send control and receive ring
// Assumes: One clock, async active-low reset
// Notes: Bound to the top module
`timescale 1ns/1ns
`default_nettype none
module eth_ring_chk import eth_ring_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic rx_valid_i,
	input wire logic mem_wr_en_o,
	input wire logic [15:0] mem_wr_addr_o,
	input wire logic mem_rd_en_o,
	input wire logic tx_valid_o,
	input wire logic tx_ready_i,
	input wire logic [7:0] tx_data_o,
	input wire logic send_done_o,
	input wire logic send_abort_o
);
	default clocking dc @(posedge sys_clk_i);
	endclocking
	default disable iff (!reset_n_i);
	sequence held_byte;
		tx_valid_o && !tx_ready_i;
	endsequence
	chk_wr_cause: assert property (mem_wr_en_o |-> $past(rx_valid_i)) else $error("stray write");
	chk_wr_range: assert property (mem_wr_en_o |-> mem_wr_addr_o <= MEM_LAST) else $error("addr");
	chk_tx_hold: assert property (held_byte |=> tx_valid_o && $stable(tx_data_o)) else $error("hold");
	chk_rd_gap: assert property (mem_rd_en_o |=> !mem_rd_en_o) else $error("read gap");
	chk_done_pulse: assert property (send_done_o |=> !send_done_o) else $error("done");
	chk_done_idle: assert property (send_done_o |-> !tx_valid_o) else $error("done busy");
	chk_abort_pulse: assert property (send_abort_o |=> !send_abort_o) else $error("abort");
	chk_done_excl: assert property (!(send_done_o && send_abort_o)) else $error("both");
endmodule
bind eth_tx_control_rx_ring eth_ring_chk i_chk (.*);
`default_nettype wire

//--- dv/eth_tx_control_rx_ring_tb.sv
// Purpose: Register-level tests of send control and receive ring
// Assumes: MAC model partner, 8 ns clock
// Notes: Memory returns the low address byte
`timescale 1ns/1ns
`default_nettype none
module eth_tx_control_rx_ring_tb;
	logic sys_clk_i, reset_n_i, reg_wr_i, reg_rd_i, mem_rd_en_o, mem_wr_en_o, tx_valid_o;
	logic tx_ready_i, tx_last_o, tx_crc_append_o, jam_o, send_done_o, send_abort_o, link_up_i;
	logic pause_hold_i, wire_byte_i, mac_done_i, collision_i, late_collision_i, excess_wait_i;
	logic waited_i, checksum_mismatch_i, rx_valid_i, rx_last_i, rx_reject_i, slow;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, mem_rd_data_i, mem_wr_data_o, tx_data_o;
	logic [7:0] rx_data_i, d;
	logic [15:0] mem_rd_addr_o, mem_wr_addr_o;
	logic [15:0] rv [9] = '{16'h0202, 16'h08ee, 16'h0905, 16'h0a00, 16'h0b30, 16'h0cfe,
		16'h0d5f, 16'h0e00, 16'h0f30};
	int n_fail = 0, n_compared = 0;
	eth_tx_control_rx_ring i_dut (.*);
	eth_mac_model i_mac (.sys_clk_i, .reset_n_i, .tx_valid_i(tx_valid_o), .tx_last_i(tx_last_o),
		.slow_i(slow), .tx_ready_o(tx_ready_i), .wire_byte_o(wire_byte_i), .mac_done_o(mac_done_i));
	initial begin
		sys_clk_i = 0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	logic [8:0] last_tx;
	logic [11:0] ev;
	always_comb mem_rd_data_i = mem_rd_addr_o[7:0];
	always_ff @(posedge sys_clk_i) begin
		if (tx_valid_o && tx_ready_i && tx_last_o) begin
			last_tx <= {tx_crc_append_o, tx_data_o};
		end
	end
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ev <= '0;
		end else begin
			ev <= ev + {3'h0, send_done_o, 3'h0, send_abort_o, 3'h0, jam_o};
		end
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk_i) #1;
		{reg_addr_i, reg_wdata_i, reg_wr_i} = {a, v, 1'b1};
		@(posedge sys_clk_i) #1;
		reg_wr_i = 0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk_i) #1;
		{reg_addr_i, reg_rd_i} = {a, 1'b1};
		@(posedge sys_clk_i) #1;
		reg_rd_i = 0;
		d = reg_rdata_o;
	endtask
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		cmp({8'h00, d}, {8'h00, e});
	endtask
	task automatic w16(input logic [7:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 8'h01, v[15:8]);
	endtask
	task automatic snd(input logic [15:0] n);
		w16(8'h06, n);
		wr(8'h00, 8'h02);
	endtask
	task automatic wt;
		d = 8'h02;
		for (int i = 0; i < 300 && d[1] !== 1'b0; i++) rd(8'h00);
		cmp({15'h0000, d[1]}, 16'h0000);
	endtask
	task automatic rxf(input int n, input logic rej);
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk_i) #1;
			{rx_valid_i, rx_last_i, rx_reject_i, rx_data_i} = {1'b1, i == n - 1, rej, 8'(i)};
		end
		@(posedge sys_clk_i) #1;
		{rx_valid_i, rx_last_i} = 2'b00;
	endtask
	task final_report;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		{reset_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, rx_data_i, d} = '0;
		{pause_hold_i, collision_i, late_collision_i, excess_wait_i, waited_i} = '0;
		{checksum_mismatch_i, rx_valid_i, rx_last_i, rx_reject_i, slow, link_up_i} = 6'h01;
		repeat (5) @(posedge sys_clk_i);
		#1 reset_n_i = 1;
		foreach (rv[i]) rc(rv[i][15:8], rv[i][7:0]);
		w16(8'h06, 16'h0007);
		wr(8'h00, 8'h02);
		rc(8'h00, 8'h00);
		slow = 1;
		w16(8'h04, 16'h2ffc);
		snd(16'h0008);
		wt;
		rc(8'h12, 8'h08);
		cmp({7'h00, last_tx}, 16'h0103);
		rc(8'h04, 8'hfc);
		rc(8'h06, 8'h08);
		slow = 0;
		w16(8'h08, 16'h000a);
		snd(16'h0020);
		wt;
		rc(8'h12, 8'h0a);
		cmp({7'h00, last_tx}, 16'h0005);
		snd(16'h0020);
		repeat (4) @(posedge sys_clk_i);
		#1 late_collision_i = 1;
		@(posedge sys_clk_i) #1 late_collision_i = 0;
		wt;
		rc(8'h11, 8'h04);
		snd(16'h0020);
		wr(8'h00, 8'h00);
		rc(8'h00, 8'h00);
		cmp({4'h0, ev}, 16'h0221);
		link_up_i = 0;
		snd(16'h0008);
		wt;
		rc(8'h12, 8'h00);
		wr(8'h02, 8'h0b);
		pause_hold_i = 1;
		snd(16'h0008);
		repeat (8) @(posedge sys_clk_i);
		rc(8'h00, 8'h02);
		pause_hold_i = 0;
		wt;
		cmp({4'h0, ev}, 16'h0421);
		wr(8'h00, 8'h01);
		rxf(3, 1'b0);
		rc(8'h03, 8'h01);
		rc(8'h0e, 8'h04);
		rc(8'h0f, 8'h30);
		rxf(2, 1'b1);
		rc(8'h0e, 8'h04);
		w16(8'h0c, 16'h3006);
		rxf(4, 1'b0);
		rc(8'h0e, 8'h04);
		rc(8'h03, 8'h01);
		wr(8'h01, 8'h01);
		rc(8'h03, 8'h00);
		final_report;
	end
	initial begin
		#100000;
		n_fail++;
		$display("[ERR] %0t watchdog expired", $time);
		final_report;
	end
endmodule
`default_nettype wire
